// >>> csp_pkg.sv
// csp_pkg: shared constants and types for the configurable serial port
// assumes nothing beyond a SystemVerilog compiler
package csp_pkg;
  localparam int WORD_W = 8;
  localparam int FIFO_DEPTH = 8;
  localparam int PTR_W = 3;
  localparam int CNT_W = 4;
  localparam int SCK_HALF_NS = 100;
  localparam int CLK_NS = 20;
  localparam int SCK_HALF_CYC = (SCK_HALF_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [7:0] SCK_HALF_LAST = 8'(SCK_HALF_CYC - 1);
  localparam logic [CNT_W-1:0] BITS_LAST = 4'h7;
  localparam logic [WORD_W-1:0] WORD_RST = 8'h00;
  typedef enum logic [1:0] {CSP_IDLE, CSP_LEAD, CSP_TRAIL} csp_state_t;
endpackage

// >>> csp_port.sv
// csp_port: spi master/slave port with transmit and receive fifos
// assumes synchronous inputs; slave clock slower than a quarter of i_clock
// Function
// RQ1: select lines driven in master mode, sampled in slave mode, polarity programmable.
// RQ2: master shifts out on master-out; slave receives from it.
// RQ3: master captures master-in; slave drives it with transmit data.
// RQ4: serial clock generated in master mode, taken as input in slave mode.
// RQ5: data-ready input used for flow control only in master mode.
// RQ6: burst start triggered by data-ready edge or level, selectable.
// RQ7: with flow control enabled, master waits until slave reports ready.
// RQ8: separate transmit and receive fifos; master or slave selectable.
// RQ9: two select lines; only the programmed one asserted during a burst.
// RQ10: transmit fifo empty ends burst: clock stops, select released after word.
`timescale 1ns/1ps
`default_nettype none
module csp_port (
  input wire logic i_clock,
  input wire logic i_nrst,
  input wire logic i_enable,
  input wire logic i_master_mode,
  input wire logic i_select_idx,
  input wire logic [1:0] i_select_act_high,
  input wire logic i_flow_en,
  input wire logic i_trig_level,
  input wire logic [7:0] i_tx_data,
  input wire logic i_tx_valid,
  output logic o_tx_ready,
  output logic [7:0] o_rx_data,
  output logic o_rx_valid,
  input wire logic i_rx_ready,
  input wire logic [1:0] i_slave_select_in,
  output logic [1:0] o_slave_select_out,
  output logic [1:0] o_slave_select_oe_n,
  input wire logic i_master_out_line_in,
  output logic o_master_out_line_out,
  output logic o_master_out_line_oe_n,
  input wire logic i_master_in_line_in,
  output logic o_master_in_line_out,
  output logic o_master_in_line_oe_n,
  input wire logic i_serial_clock_line_in,
  output logic o_serial_clock_line_out,
  output logic o_serial_clock_line_oe_n,
  input wire logic i_slave_data_ready,
  output logic o_busy
);
  localparam int W = csp_pkg::WORD_W;
  localparam int D = csp_pkg::FIFO_DEPTH;
  localparam int P = csp_pkg::PTR_W;

  function automatic logic [P:0] ptr_inc(input logic [P:0] p);
    ptr_inc = p + 1'b1;
  endfunction
  function automatic logic is_full(input logic [P:0] w, input logic [P:0] r);
    is_full = (w[P] != r[P]) && (w[P-1:0] == r[P-1:0]);
  endfunction

  // fifo storage [RQ8]
  logic [W-1:0] txm_q [D];
  logic [W-1:0] rxm_q [D];
  logic [P:0] txw_q, txw_d, txr_q, txr_d, rxw_q, rxw_d, rxr_q, rxr_d;
  logic tx_push, tx_pop, rx_push, rx_pop, tx_empty, rx_empty;
  logic [W-1:0] rx_word;

  csp_pkg::csp_state_t st_q, st_d;
  logic [W-1:0] sh_q, sh_d;
  logic [csp_pkg::CNT_W-1:0] bit_q, bit_d;
  logic [7:0] div_q, div_d;
  logic sck_q, sck_d, act_q, act_d, rdy_q, rdy_d, arm_q, arm_d;
  logic ssel_q, ssel_d, sckin_q, sckin_d, mo_q, mo_d, mi_q, mi_d;
  logic [1:0] sso_q, sso_d, ssoe_q, ssoe_d;
  logic moo_q, moo_d, mooe_q, mooe_d, mio_q, mio_d, mioe_q, mioe_d, scko_q, scko_d, sckoe_q, sckoe_d;
  logic txrdy_q, txrdy_d, rxv_q, rxv_d, busy_q, busy_d;
  logic [W-1:0] rxd_q, rxd_d;
  logic start_ok, sel_in_act, s_rise, s_fall, rdy_rise, pre_q, pre_d;

  assign tx_empty = (txw_q == txr_q);
  assign rx_empty = (rxw_q == rxr_q);
  assign tx_push = i_tx_valid && txrdy_q && !is_full(txw_q, txr_q);
  assign rx_pop = rxv_q && i_rx_ready;
  // slave select of the chosen line at its programmed level [RQ1]
  assign sel_in_act = (i_slave_select_in[i_select_idx] == i_select_act_high[i_select_idx]);
  assign s_rise = !sckin_q && i_serial_clock_line_in;
  assign s_fall = sckin_q && !i_serial_clock_line_in;
  assign rdy_rise = i_slave_data_ready && !rdy_q;
  // edge or level trigger on data-ready, master only [RQ5] [RQ6] [RQ7]
  assign start_ok = !i_flow_en || (i_trig_level ? i_slave_data_ready : (arm_q || rdy_rise));

  always_comb begin
    st_d = st_q;
    sh_d = sh_q;
    bit_d = bit_q;
    div_d = div_q;
    sck_d = sck_q;
    act_d = act_q;
    tx_pop = 1'b0;
    rx_push = 1'b0;
    rx_word = sh_q;
    rdy_d = i_slave_data_ready;
    arm_d = arm_q || rdy_rise;
    pre_d = pre_q;
    ssel_d = sel_in_act;
    sckin_d = i_serial_clock_line_in;
    mo_d = mo_q;
    mi_d = mi_q;
    if (i_master_mode) begin
      pre_d = 1'b0;
      case (st_q)
        csp_pkg::CSP_IDLE: begin
          sck_d = 1'b0;
          act_d = 1'b0;
          if (!tx_empty && start_ok) begin
            sh_d = txm_q[txr_q[P-1:0]];
            tx_pop = 1'b1;
            // a fresh edge in the start cycle stays armed for the next word only if an earlier edge was already armed
            arm_d = arm_q && rdy_rise;
            act_d = 1'b1; // [RQ9]
            bit_d = '0;
            div_d = '0;
            st_d = csp_pkg::CSP_LEAD;
          end
        end
        csp_pkg::CSP_LEAD: begin
          if (div_q == csp_pkg::SCK_HALF_LAST) begin
            div_d = '0;
            sck_d = 1'b1; // [RQ4]
            mi_d = i_master_in_line_in; // [RQ3]
            st_d = csp_pkg::CSP_TRAIL;
          end else begin
            div_d = div_q + 8'h01;
          end
        end
        csp_pkg::CSP_TRAIL: begin
          if (div_q == csp_pkg::SCK_HALF_LAST) begin
            div_d = '0;
            sck_d = 1'b0;
            sh_d = {sh_q[W-2:0], mi_q}; // [RQ2] [RQ3]
            if (bit_q == csp_pkg::BITS_LAST) begin
              rx_word = {sh_q[W-2:0], mi_q};
              rx_push = !is_full(rxw_q, rxr_q);
              bit_d = '0;
              // empty fifo ends the burst after this word [RQ10]
              if (!tx_empty && start_ok) begin
                sh_d = txm_q[txr_q[P-1:0]];
                tx_pop = 1'b1;
                arm_d = arm_q && rdy_rise;
                st_d = csp_pkg::CSP_LEAD;
              end else begin
                act_d = 1'b0;
                st_d = csp_pkg::CSP_IDLE;
              end
            end else begin
              bit_d = bit_q + 4'h1;
              st_d = csp_pkg::CSP_LEAD;
            end
          end else begin
            div_d = div_q + 8'h01;
          end
        end
        default: st_d = csp_pkg::CSP_IDLE;
      endcase
    end else begin
      // slave: external clock, mode 0, data-ready ignored [RQ4] [RQ5]
      st_d = csp_pkg::CSP_IDLE;
      sck_d = 1'b0;
      act_d = 1'b0;
      arm_d = 1'b0;
      if (!ssel_q) begin
        bit_d = '0;
        // preload one word only, so the fifo is not drained while deselected
        if (!tx_empty && !pre_q) begin
          sh_d = txm_q[txr_q[P-1:0]];
          tx_pop = 1'b1;
          pre_d = 1'b1;
        end
      end else if (s_rise) begin
        mo_d = i_master_out_line_in; // [RQ2]
      end else if (s_fall) begin
        sh_d = {sh_q[W-2:0], mo_q}; // [RQ3]
        if (bit_q == csp_pkg::BITS_LAST) begin
          rx_word = {sh_q[W-2:0], mo_q};
          rx_push = !is_full(rxw_q, rxr_q);
          bit_d = '0;
          pre_d = !tx_empty;
          if (!tx_empty) begin
            sh_d = txm_q[txr_q[P-1:0]];
            tx_pop = 1'b1;
          end
        end else begin
          bit_d = bit_q + 4'h1;
        end
      end
    end
    txw_d = tx_push ? ptr_inc(txw_q) : txw_q;
    txr_d = tx_pop ? ptr_inc(txr_q) : txr_q;
    rxw_d = rx_push ? ptr_inc(rxw_q) : rxw_q;
    rxr_d = rx_pop ? ptr_inc(rxr_q) : rxr_q;
  end

  // pin drivers, oe low means driving [RQ1] [RQ9]
  always_comb begin
    txrdy_d = !is_full(txw_d, txr_d);
    rxv_d = (rxw_d != rxr_d);
    rxd_d = rx_empty ? rxd_q : rxm_q[rxr_d[P-1:0]];
    // new head is the word being written this cycle: bypass the array
    if (rx_push && (rxr_d == rxw_q)) rxd_d = rx_word;
    busy_d = act_d;
    sso_d[0] = (act_d && !i_select_idx) ? i_select_act_high[0] : !i_select_act_high[0];
    sso_d[1] = (act_d && i_select_idx) ? i_select_act_high[1] : !i_select_act_high[1];
    ssoe_d = i_master_mode ? 2'h0 : 2'h3;
    moo_d = sh_d[W-1];
    mooe_d = !i_master_mode;
    mio_d = sh_d[W-1];
    mioe_d = i_master_mode || !ssel_d;
    scko_d = sck_d;
    sckoe_d = !i_master_mode;
  end

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      st_q <= csp_pkg::CSP_IDLE;
      sh_q <= csp_pkg::WORD_RST;
      bit_q <= '0;
      div_q <= '0;
      {sck_q, act_q, rdy_q, arm_q, ssel_q, sckin_q, mo_q, mi_q} <= '0;
      pre_q <= 1'b0;
      {txw_q, txr_q, rxw_q, rxr_q} <= '0;
      sso_q <= 2'h0;
      ssoe_q <= 2'h3;
      {moo_q, mio_q, scko_q, txrdy_q, rxv_q, busy_q} <= '0;
      {mooe_q, mioe_q, sckoe_q} <= 3'h7;
      rxd_q <= csp_pkg::WORD_RST;
    end else if (i_enable) begin
      st_q <= st_d;
      sh_q <= sh_d;
      bit_q <= bit_d;
      div_q <= div_d;
      {sck_q, act_q, rdy_q, arm_q, ssel_q, sckin_q, mo_q, mi_q} <= {sck_d, act_d, rdy_d, arm_d, ssel_d, sckin_d, mo_d, mi_d};
      pre_q <= pre_d;
      {txw_q, txr_q, rxw_q, rxr_q} <= {txw_d, txr_d, rxw_d, rxr_d};
      sso_q <= sso_d;
      ssoe_q <= ssoe_d;
      {moo_q, mio_q, scko_q, txrdy_q, rxv_q, busy_q} <= {moo_d, mio_d, scko_d, txrdy_d, rxv_d, busy_d};
      {mooe_q, mioe_q, sckoe_q} <= {mooe_d, mioe_d, sckoe_d};
      rxd_q <= rxd_d;
    end
  end

  // fifo arrays, no reset needed
  always_ff @(posedge i_clock) begin
    if (i_enable && tx_push) txm_q[txw_q[P-1:0]] <= i_tx_data;
    if (i_enable && rx_push) rxm_q[rxw_q[P-1:0]] <= rx_word;
  end

  assign o_tx_ready = txrdy_q;
  assign o_rx_data = rxd_q;
  assign o_rx_valid = rxv_q;
  assign o_slave_select_out = sso_q;
  assign o_slave_select_oe_n = ssoe_q;
  assign o_master_out_line_out = moo_q;
  assign o_master_out_line_oe_n = mooe_q;
  assign o_master_in_line_out = mio_q;
  assign o_master_in_line_oe_n = mioe_q;
  assign o_serial_clock_line_out = scko_q;
  assign o_serial_clock_line_oe_n = sckoe_q;
  assign o_busy = busy_q;
endmodule
`default_nettype wire

// >>> csp_port_properties.sv
// csp_port_props: pin direction and serial timing checks on the serial port
// assumes binding onto csp_port, one clock, async active-low reset
`timescale 1ns/1ps
`default_nettype none
module csp_port_props (
  input wire logic i_clock,
  input wire logic i_nrst,
  input wire logic i_master_mode,
  input wire logic i_select_idx,
  input wire logic [1:0] i_select_act_high,
  input wire logic i_flow_en,
  input wire logic i_trig_level,
  input wire logic i_slave_data_ready,
  input wire logic i_rx_ready,
  input wire logic o_rx_valid,
  input wire logic [7:0] o_rx_data,
  input wire logic o_busy,
  input wire logic [1:0] o_slave_select_out,
  input wire logic [1:0] o_slave_select_oe_n,
  input wire logic o_master_out_line_oe_n,
  input wire logic o_master_in_line_oe_n,
  input wire logic o_serial_clock_line_out,
  input wire logic o_serial_clock_line_oe_n
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_nrst);
  logic [1:0] act_sel;
  assign act_sel = i_select_idx ? {i_select_act_high[1], ~i_select_act_high[0]} :
    {~i_select_act_high[1], i_select_act_high[0]};
  sequence s_lead;
    !o_serial_clock_line_out [*5];
  endsequence
  sequence s_rise;
    o_serial_clock_line_out;
  endsequence
  a_burst_drives: assert property (o_busy |-> o_slave_select_oe_n == 2'h0 &&
    !o_master_out_line_oe_n && !o_serial_clock_line_oe_n) else $error("burst pins undriven");
  a_master_reads: assert property (i_master_mode |-> o_master_in_line_oe_n) else $error("miso driven");
  a_slave_inputs: assert property (!i_master_mode [*2] |-> o_slave_select_oe_n == 2'h3 &&
    o_serial_clock_line_oe_n && o_master_out_line_oe_n) else $error("slave drives pins");
  a_select_only: assert property (o_busy |-> o_slave_select_out == act_sel) else $error("wrong select");
  a_idle_release: assert property ($past(i_nrst) && i_master_mode && !o_busy && !$past(o_busy) &&
    $stable(i_select_act_high) |-> o_slave_select_out == ~i_select_act_high && !o_serial_clock_line_out)
    else $error("idle select or clock active");
  a_start_lead: assert property ($rose(o_busy) |-> s_lead ##1 s_rise) else $error("lead wrong");
  a_clock_high: assert property (o_busy && $rose(o_serial_clock_line_out) |->
    o_serial_clock_line_out [*5] ##1 !o_serial_clock_line_out) else $error("high phase wrong");
  a_flow_hold: assert property ((i_master_mode && i_flow_en && i_trig_level && !i_slave_data_ready &&
    !o_busy) [*3] |=> !o_busy) else $error("burst without ready");
  a_rx_hold: assert property (o_rx_valid && !i_rx_ready |=> o_rx_valid && $stable(o_rx_data))
    else $error("rx head lost");
endmodule
bind csp_port csp_port_props u_props (.*);
`default_nettype wire

// >>> csp_slave_model.sv
// csp_slave_model: external spi slave, mode 0, msb first
// assumes the select input already resolved to active-true
`timescale 1ns/1ps
`default_nettype none
module csp_slave_model (
  input wire logic i_sck,
  input wire logic i_sel,
  input wire logic i_mosi,
  input wire logic [7:0] i_word,
  output logic o_miso,
  output logic [15:0] o_got,
  output int o_words
);
  logic [7:0] sh = 8'h00;
  int n = 0;
  initial o_miso = 1'b0;
  initial o_got = 16'h0000;
  initial o_words = 0;
  always @(i_sel) begin
    n = 0;
    sh = i_word;
    o_miso = i_sel ? i_word[7] : ~o_miso; // released line shows no stale bit
  end
  always @(negedge i_sck) if (i_sel) o_miso = sh[7];
  always @(posedge i_sck) if (i_sel) begin
    sh = {sh[6:0], i_mosi};
    n++;
    if (n == 8) begin
      o_got = {o_got[7:0], sh};
      o_words++;
      n = 0;
      sh = i_word;
    end
  end
endmodule
`default_nettype wire

// >>> csp_port_tb.sv
// testbench: master bursts, flow control and slave mode of csp_port
// assumes the slave model on the serial pins, 50 MHz clock
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic i_clock = 1'b0, i_nrst = 1'b0, i_enable = 1'b1, i_master_mode = 1'b1, i_select_idx = 1'b0;
  logic i_flow_en = 1'b0, i_trig_level = 1'b1, i_tx_valid = 1'b0, i_rx_ready = 1'b0, i_slave_data_ready = 1'b0;
  logic tb_sck = 1'b0, tb_mosi = 1'b0, o_tx_ready, o_rx_valid, o_busy, slv_miso, i_master_out_line_in;
  logic o_master_out_line_out, o_master_out_line_oe_n, o_master_in_line_out, o_master_in_line_oe_n;
  logic i_master_in_line_in, o_serial_clock_line_out, o_serial_clock_line_oe_n, i_serial_clock_line_in;
  logic [1:0] i_select_act_high = 2'h0, tb_sel = 2'h3, i_slave_select_in, o_slave_select_out, o_slave_select_oe_n;
  logic [7:0] i_tx_data = 8'h00, o_rx_data;
  logic [15:0] got;
  int err_total = 0, tests_run = 0, words;
  assign i_slave_select_in = (o_slave_select_oe_n & tb_sel) | (~o_slave_select_oe_n & o_slave_select_out);
  assign i_serial_clock_line_in = o_serial_clock_line_oe_n ? tb_sck : o_serial_clock_line_out;
  assign i_master_out_line_in = o_master_out_line_oe_n ? tb_mosi : o_master_out_line_out;
  assign i_master_in_line_in = o_master_in_line_oe_n ? slv_miso : o_master_in_line_out;
  csp_port DUT (.*);
  csp_slave_model u_slave (.i_sck(i_serial_clock_line_in), .i_mosi(i_master_out_line_in), .i_word(8'hC3),
    .i_sel(i_slave_select_in[i_select_idx] == i_select_act_high[i_select_idx]), .o_miso(slv_miso),
    .o_got(got), .o_words(words));
  always #10 i_clock = ~i_clock;
  task tally_and_finish;
    $display("checks %0d errors %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("Error %0t saw %h expected %h", $time, seen, exp);
    end
  endtask
  task wait_words(input int n);
    int k;
    for (k = 0; k < 3000 && (words < n || o_busy !== 1'b0); k++) @(negedge i_clock);
    if (k == 3000) begin
      err_total++;
      $display("Error %0t wait expired", $time);
      tally_and_finish;
    end
  endtask
  task push(input logic [7:0] a, input logic [7:0] b);
    i_tx_valid = 1'b1;
    i_tx_data = a;
    @(negedge i_clock);
    i_tx_data = b;
    @(negedge i_clock);
    i_tx_valid = 1'b0;
  endtask
  task pop2(input logic [7:0] a, input logic [7:0] b);
    check(16'({o_rx_valid, o_rx_data}), 16'({1'b1, a}));
    i_rx_ready = 1'b1;
    @(negedge i_clock);
    i_rx_ready = 1'b0;
    @(negedge i_clock);
    check(16'({o_rx_valid, o_rx_data}), 16'({1'b1, b}));
    i_rx_ready = 1'b1;
    @(negedge i_clock);
    i_rx_ready = 1'b0;
    @(negedge i_clock);
    check(16'(o_rx_valid), 16'h0000);
  endtask
  task t_master(input logic idx, input logic [1:0] pol);
    int w;
    logic [1:0] idle_sel;
    w = words;
    idle_sel = ~pol;
    i_select_idx = idx;
    i_select_act_high = pol;
    @(negedge i_clock);
    check(16'(o_tx_ready), 16'h0001);
    push(8'hA5, 8'h3C);
    // freeze mid-burst while the serial clock is low: nothing may advance
    repeat (20) @(negedge i_clock);
    i_enable = 1'b0;
    repeat (200) @(negedge i_clock);
    check(16'(words - w), 16'h0000);
    check(16'({o_busy, o_serial_clock_line_out}), 16'h0002);
    i_enable = 1'b1;
    wait_words(w + 2);
    check(got, 16'hA53C);
    check(16'(i_slave_select_in), 16'(idle_sel));
    pop2(8'hC3, 8'hC3);
    $display("t_master done");
  endtask
  task t_flow(input logic lvl);
    int w;
    w = words;
    i_flow_en = 1'b1;
    i_trig_level = lvl;
    push(8'h5A, 8'h81);
    repeat (40) @(negedge i_clock);
    check(16'(o_busy), 16'h0000);
    i_slave_data_ready = 1'b1;
    wait_words(w + 1);
    if (!lvl) begin
      repeat (150) @(negedge i_clock);
      check(16'(words - w), 16'h0001);
      i_slave_data_ready = 1'b0;
      @(negedge i_clock);
      i_slave_data_ready = 1'b1;
      wait_words(w + 2);
    end
    check(got, 16'h5A81);
    i_slave_data_ready = 1'b0;
    pop2(8'hC3, 8'hC3);
    $display("t_flow done");
  endtask
  task t_slave;
    int i;
    logic [15:0] m;
    logic [15:0] s;
    m = 16'h2BD4;
    s = 16'h6E91;
    i_master_mode = 1'b0;
    i_select_idx = 1'b0;
    i_select_act_high = 2'h0;
    i_slave_data_ready = 1'b1;
    push(s[15:8], s[7:0]);
    tb_sel = 2'h2;
    repeat (5) @(negedge i_clock);
    for (i = 15; i >= 0; i--) begin
      tb_mosi = m[i];
      repeat (5) @(negedge i_clock);
      check(16'(i_master_in_line_in), 16'(s[i]));
      tb_sck = 1'b1;
      repeat (5) @(negedge i_clock);
      tb_sck = 1'b0;
    end
    repeat (5) @(negedge i_clock);
    tb_sel = 2'h3;
    check(16'({o_busy, o_slave_select_oe_n}), 16'h0003);
    pop2(m[15:8], m[7:0]);
    $display("t_slave done");
  endtask
  initial begin
    repeat (6) @(negedge i_clock);
    i_nrst = 1'b1;
    repeat (2) @(negedge i_clock);
    t_master(1'b0, 2'h0);
    t_master(1'b1, 2'h2);
    t_flow(1'b1);
    t_flow(1'b0);
    t_slave;
    tally_and_finish;
  end
endmodule
`default_nettype wire
